/* File: rtl/trinary_code_pair.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1: nine trinary code inputs, five address, four shared
// R2: low request starts sequence, pulse gives two words
// R3: receiver should ignore first word after power-up; the decoder here uses it as the first of the two matching words
// R4: three idle data periods between the words
// R5: digit is two pulses, short or long
// R6: weak drive high then low classifies input
// R7: request high after second word stops oscillator
// R8: request low starts oscillator, probes, shifts out
// R9: external clock drives series input, others open; here the oscillator is MCLK divided by OSC_DIV, with no oscillator pins
// R10: first five received digits compared as address
// R11: first word match stores nibble internally only
// R12: second match with equal nibble loads latch
// R13: valid rises with latch, drops on error/silence
// R14: open data digit decodes as logic one
// R15: address-only variant compares nine digits, no data
// R16: local address trinary or binary, levels must equal
// R17: pulse wide if longer than 1.72 periods
// R18: end of transmission after 33.5 periods low
// R19: word gap at 0.4 of end timeout
// R20: reset clears outputs, stored nibble, match state
// R21: decoder timing by counters, encoder period parameters
// R22: encoder pulse widths fixed multiples of oscillator
module trinary_code_pair
    import code_pair_pkg::*;
#(
    parameter int OSC_HZ_P = OSC_HZ,
    parameter bit ADDR_ONLY = 1'b0
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // encoder request and serial output
    input wire logic SEND_REQUEST_N,
    output logic ENC_SERIAL_OUT,
    // encoder address digit pins
    input wire logic [ADDR_DIGITS-1:0] ADDRESS_DIGITS_IN,
    output logic [ADDR_DIGITS-1:0] ADDRESS_DIGITS_OUT,
    output logic [ADDR_DIGITS-1:0] ADDRESS_DIGITS_OE_N,
    // encoder shared address or data digit pins
    input wire logic [DATA_DIGITS-1:0] SHARED_ADDR_DATA_DIGITS_IN,
    output logic [DATA_DIGITS-1:0] SHARED_ADDR_DATA_DIGITS_OUT,
    output logic [DATA_DIGITS-1:0] SHARED_ADDR_DATA_DIGITS_OE_N,
    // decoder serial input and local address
    input wire logic DEC_SERIAL_IN,
    input wire logic [2*DIGITS-1:0] LOCAL_ADDRESS,
    // decoder outputs
    output logic [DATA_DIGITS-1:0] DECODED_NIBBLE_OUT,
    output logic VALID_RECEPTION
);

    typedef enum {ENC_IDLE, ENC_PROBE, ENC_SEND, ENC_GAP} enc_state_e;
    localparam int OSC_DIV = MCLK_HZ / OSC_HZ_P;
    localparam int GAP_TICKS = WORD_GAP_PERIODS * PERIOD_OSC;
    localparam int EOT_INT = (EOT_X10 * OSC_DIV) / 10;
    localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_DIV - 1);
    localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_TICKS - 1);
    localparam logic [CNT_W-1:0] NARROW_CYC =
        CNT_W'((NARROW_X100 * OSC_DIV) / 100);
    localparam logic [CNT_W-1:0] EOT_CYC = CNT_W'(EOT_INT);
    localparam logic [CNT_W-1:0] GAP_CYC =
        CNT_W'((EOT_INT * GAP_OF_EOT_X10) / 10);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam int MATCH_DIGITS = ADDR_ONLY ? DIGITS : ADDR_DIGITS;

    // two probe samples to a level
    function automatic trit_t classify(input logic hi, input logic lo);
        if (hi == lo) begin
            classify = hi ? TRIT_HIGH : TRIT_LOW;
        end else begin
            classify = TRIT_OPEN;
        end
    endfunction
    // pulse pair to a level
    function automatic trit_t pair_trit(input logic w0, input logic w1);
        case ({w0, w1})
            2'b00: pair_trit = TRIT_LOW;
            2'b11: pair_trit = TRIT_HIGH;
            2'b10: pair_trit = TRIT_OPEN;
            default: pair_trit = TRIT_BAD;
        endcase
    endfunction
    // counter step that sticks at the top
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        sat_inc = (c == CNT_MAX) ? c : c + 1'b1;
    endfunction

    // ---------------- encoder ----------------
    enc_state_e enc_state;
    logic [CNT_W-1:0] osc_cnt;
    logic osc_tick;
    logic [3:0] digit;
    logic [2:0] phase;
    logic [2:0] probe_step;
    logic probe_hi;
    logic second_word;
    logic [CNT_W-1:0] gap_cnt;
    logic [2*DIGITS-1:0] tx_word;
    probe_drive_s drive;
    logic dout;
    logic [DIGITS-1:0] pin_in;
    trit_t cur_trit;
    logic cur_wide;
    logic [1:0] sub;
    logic level;
    assign pin_in = {SHARED_ADDR_DATA_DIGITS_IN, ADDRESS_DIGITS_IN};
    assign cur_trit = tx_word[{digit, 1'b0} +: 2];
    assign sub = phase[1:0];

    // long pulse for high, and first pulse of open
    always_comb begin
        cur_wide = (cur_trit == TRIT_HIGH) ||
                   ((cur_trit == TRIT_OPEN) && !phase[2]);
        level = (sub < (cur_wide ? 2'(LONG_HIGH_OSC) : 2'(SHORT_HIGH_OSC)));
    end

    // oscillator held still while idle
    always_ff @(posedge MCLK) begin
        if (!RESETN || enc_state == ENC_IDLE) begin // [R7]
            osc_cnt <= '0;
            osc_tick <= 1'b0;
        end else if (osc_cnt == OSC_LAST) begin // [R21] [R22]
            osc_cnt <= '0;
            osc_tick <= 1'b1;
        end else begin
            osc_cnt <= osc_cnt + 1'b1;
            osc_tick <= 1'b0;
        end
    end

    // sequence control, probing and shifting
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            enc_state <= ENC_IDLE;
            digit <= 4'h0;
            phase <= 3'h0;
            probe_step <= 3'h0;
            probe_hi <= 1'b0;
            second_word <= 1'b0;
            gap_cnt <= '0;
            tx_word <= '0;
            drive.out <= '0;
            drive.oe_n <= '1;
            dout <= 1'b0;
        end else begin
            unique case (enc_state)
                ENC_IDLE: begin
                    dout <= 1'b0;
                    if (!SEND_REQUEST_N) begin // [R2] [R8]
                        enc_state <= ENC_PROBE;
                        digit <= 4'h0;
                        probe_step <= 3'h0;
                        second_word <= 1'b0;
                    end
                end
                ENC_PROBE: begin
                    probe_step <= probe_step + 1'b1;
                    if (probe_step == 3'h0) begin // [R6]
                        drive.out[digit] <= 1'b1;
                        drive.oe_n[digit] <= 1'b0;
                    end else if (probe_step == 3'(PROBE_SETTLE)) begin
                        probe_hi <= pin_in[digit];
                        drive.out[digit] <= 1'b0;
                    end else if (probe_step == 3'(2 * PROBE_SETTLE)) begin
                        // [R1] [R6]
                        tx_word[{digit, 1'b0} +: 2] <=
                            classify(probe_hi, pin_in[digit]);
                        drive.oe_n[digit] <= 1'b1;
                        probe_step <= 3'h0;
                        if (digit == 4'(DIGITS - 1)) begin // [R8]
                            enc_state <= ENC_SEND;
                            digit <= 4'h0;
                            phase <= 3'h0;
                        end else begin
                            digit <= digit + 1'b1;
                        end
                    end
                end
                ENC_SEND: begin
                    if (osc_tick) begin
                        dout <= level; // [R5] [R22]
                        phase <= phase + 1'b1;
                        if (phase == 3'(PERIOD_OSC - 1)) begin
                            if (digit == 4'(DIGITS - 1)) begin
                                enc_state <= ENC_GAP;
                                gap_cnt <= '0;
                            end else begin
                                digit <= digit + 1'b1;
                            end
                        end
                    end
                end
                ENC_GAP: begin
                    if (osc_tick) begin
                        dout <= 1'b0; // [R4]
                        gap_cnt <= gap_cnt + 1'b1;
                        if (gap_cnt == GAP_LAST) begin
                            digit <= 4'h0;
                            probe_step <= 3'h0;
                            if (!second_word) begin
                                second_word <= 1'b1;
                                enc_state <= ENC_PROBE;
                            end else if (!SEND_REQUEST_N) begin // [R2]
                                second_word <= 1'b0;
                                enc_state <= ENC_PROBE;
                            end else begin // [R7]
                                second_word <= 1'b0;
                                enc_state <= ENC_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    assign ENC_SERIAL_OUT = dout;
    assign ADDRESS_DIGITS_OUT = drive.out[ADDR_DIGITS-1:0];
    assign ADDRESS_DIGITS_OE_N = drive.oe_n[ADDR_DIGITS-1:0];
    assign SHARED_ADDR_DATA_DIGITS_OUT = drive.out[DIGITS-1:ADDR_DIGITS];
    assign SHARED_ADDR_DATA_DIGITS_OE_N = drive.oe_n[DIGITS-1:ADDR_DIGITS];

    // ---------------- decoder ----------------
    logic din_q;
    logic [CNT_W-1:0] hi_cnt;
    logic [CNT_W-1:0] lo_cnt;
    pulse_track_s trk;
    logic [2*DIGITS-1:0] rx_word;
    logic fall;
    logic wide;
    logic word_end;
    logic eot;
    logic word_good;
    logic addr_ok;
    logic [DATA_DIGITS-1:0] rx_nibble;
    logic [DATA_DIGITS-1:0] stored;
    logic first_ok;
    logic [DATA_DIGITS-1:0] nibble;
    logic valid;
    trit_t new_trit;

    assign fall = din_q && !DEC_SERIAL_IN;
    assign wide = hi_cnt > NARROW_CYC; // [R17]
    assign word_end = !DEC_SERIAL_IN && lo_cnt == GAP_CYC - 1'b1; // [R19]
    assign eot = !DEC_SERIAL_IN && lo_cnt == EOT_CYC - 1'b1; // [R18]
    assign new_trit = pair_trit(trk.first_wide, wide);
    assign word_good = !trk.bad && trk.count == 5'(2 * DIGITS);

    // address compare and data extraction
    always_comb begin
        addr_ok = 1'b1;
        for (int i = 0; i < MATCH_DIGITS; i++) begin // [R10] [R15]
            if (rx_word[2*i +: 2] != LOCAL_ADDRESS[2*i +: 2]) begin // [R16]
                addr_ok = 1'b0;
            end
        end
        for (int j = 0; j < DATA_DIGITS; j++) begin
            // [R14]
            rx_nibble[j] = rx_word[2*(ADDR_DIGITS+j) +: 2] != TRIT_LOW;
        end
    end

    // pulse width and low time measurement
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            din_q <= 1'b0;
            hi_cnt <= '0;
            lo_cnt <= '0;
        end else begin
            din_q <= DEC_SERIAL_IN;
            if (DEC_SERIAL_IN) begin // [R21]
                hi_cnt <= sat_inc(hi_cnt);
                lo_cnt <= '0;
            end else begin
                hi_cnt <= '0;
                lo_cnt <= sat_inc(lo_cnt);
            end
        end
    end

    // pulse pairs into received digits
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            trk <= '0;
            rx_word <= '0;
        end else if (word_end) begin
            trk <= '0;
        end else if (fall) begin
            if (trk.count >= 5'(2 * DIGITS)) begin
                trk.bad <= 1'b1;
            end else begin
                trk.count <= trk.count + 1'b1;
                if (!trk.count[0]) begin
                    trk.first_wide <= wide;
                end else begin
                    rx_word[{trk.count[4:1], 1'b0} +: 2] <= new_trit;
                    if (new_trit == TRIT_BAD) begin
                        trk.bad <= 1'b1;
                    end
                end
            end
        end
    end

    // word checks, latch and valid flag
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin // [R20]
            nibble <= NIBBLE_RESET;
            stored <= NIBBLE_RESET;
            valid <= VALID_RESET;
            first_ok <= 1'b0;
        end else if (eot) begin // [R13] [R18]
            valid <= 1'b0;
            first_ok <= 1'b0;
        end else if (word_end && trk.count != 5'h0) begin
            if (word_good) begin
                stored <= rx_nibble; // [R11]
                first_ok <= addr_ok;
                if (first_ok && addr_ok &&
                    (ADDR_ONLY || rx_nibble == stored)) begin // [R12] [R15]
                    valid <= 1'b1; // [R13]
                    if (!ADDR_ONLY) begin
                        nibble <= rx_nibble;
                    end
                end else begin
                    valid <= 1'b0;
                end
            end else begin // [R13]
                valid <= 1'b0;
                first_ok <= 1'b0;
            end
        end
    end

    assign DECODED_NIBBLE_OUT = nibble;
    assign VALID_RECEPTION = valid;
endmodule
`default_nettype wire

/* File: rtl/code_pair_pkg.sv */
package code_pair_pkg;
    // system clock
    localparam int MCLK_HZ = 10_000_000;
    // encoder oscillator default rate
    localparam int OSC_HZ = 100_000;
    // word layout
    localparam int DIGITS = 9;
    localparam int ADDR_DIGITS = 5;
    localparam int DATA_DIGITS = 4;
    // encoder pulse timing in oscillator periods, word gap in data periods
    localparam int SHORT_HIGH_OSC = 1;
    localparam int LONG_HIGH_OSC = 3;
    localparam int FRAME_OSC = 4;
    localparam int PERIOD_OSC = 8;
    localparam int WORD_GAP_PERIODS = 3;
    // decoder thresholds in encoder oscillator periods (scaled), word gap in tenths of the end timeout
    localparam int NARROW_X100 = 172;
    localparam int EOT_X10 = 335;
    localparam int GAP_OF_EOT_X10 = 4;
    // probe settle time in system clocks
    localparam int PROBE_SETTLE = 2;
    // counter width
    localparam int CNT_W = 16;
    // trit codes
    localparam logic [1:0] TRIT_LOW = 2'h0;
    localparam logic [1:0] TRIT_HIGH = 2'h1;
    localparam logic [1:0] TRIT_OPEN = 2'h2;
    localparam logic [1:0] TRIT_BAD = 2'h3;
    // reset values
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic VALID_RESET = 1'b0;

    typedef logic [1:0] trit_t;

    // weak probe drive for the code pins
    typedef struct packed {
        logic [DIGITS-1:0] out;
        logic [DIGITS-1:0] oe_n;
    } probe_drive_s;

    // receive pulse tracking
    typedef struct packed {
        logic first_wide;
        logic bad;
        logic [4:0] count;
    } pulse_track_s;
endpackage

/* File: sim/code_pair_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module code_pair_properties
    import code_pair_pkg::*;
#(
    parameter int OSC_HZ_P = OSC_HZ
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // encoder side
    input wire logic ENC_SERIAL_OUT,
    input wire logic [ADDR_DIGITS-1:0] ADDRESS_DIGITS_OUT,
    input wire logic [ADDR_DIGITS-1:0] ADDRESS_DIGITS_OE_N,
    input wire logic [DATA_DIGITS-1:0] SHARED_ADDR_DATA_DIGITS_OE_N,
    // decoder side
    input wire logic DEC_SERIAL_IN,
    input wire logic [DATA_DIGITS-1:0] DECODED_NIBBLE_OUT,
    input wire logic VALID_RECEPTION
);
    localparam int DIV = MCLK_HZ / OSC_HZ_P;
    localparam int EOT_C = EOT_X10 * DIV / 10;
    localparam int GAP_C = EOT_C * GAP_OF_EOT_X10 / 10;
    logic [CNT_W-1:0] din_lo;
    logic [CNT_W-1:0] out_lo;
    logic [CNT_W-1:0] out_hi;
    logic [DIGITS-1:0] oe_n;
    assign oe_n = {SHARED_ADDR_DATA_DIGITS_OE_N, ADDRESS_DIGITS_OE_N};
    // run lengths of the serial lines
    always_ff @(posedge MCLK) begin
        if (!RESETN || DEC_SERIAL_IN) begin
            din_lo <= '0;
        end else if (din_lo != '1) begin
            din_lo <= din_lo + 1'b1;
        end
    end
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            out_lo <= '1;
        end else if (ENC_SERIAL_OUT) begin
            out_lo <= '0;
        end else if (out_lo != '1) begin
            out_lo <= out_lo + 1'b1;
        end
    end
    always_ff @(posedge MCLK) begin
        out_hi <= ENC_SERIAL_OUT ? out_hi + 1'b1 : '0;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    sequence probe_high;
        (ADDRESS_DIGITS_OUT[0] && !ADDRESS_DIGITS_OE_N[0]) [*2];
    endsequence
    sequence probe_low;
        (!ADDRESS_DIGITS_OUT[0] && !ADDRESS_DIGITS_OE_N[0]) [*2];
    endsequence
    a_reset_idle: assert property ($rose(RESETN) |->
        !VALID_RECEPTION && DECODED_NIBBLE_OUT == NIBBLE_RESET &&
        !ENC_SERIAL_OUT && &oe_n)
        else $error("outputs not idle after reset");
    a_one_probe: assert property ($onehot0(~oe_n))
        else $error("more than one pin probed");
    a_probe_steps: assert property ($fell(ADDRESS_DIGITS_OE_N[0]) |->
        probe_high ##1 probe_low ##1 ADDRESS_DIGITS_OE_N[0])
        else $error("probe order wrong");
    a_quiet_probe: assert property (!(&oe_n) |-> !ENC_SERIAL_OUT)
        else $error("serial output high during probe");
    a_pulse_width: assert property ($fell(ENC_SERIAL_OUT) |->
        out_hi == SHORT_HIGH_OSC * DIV || out_hi == LONG_HIGH_OSC * DIV)
        else $error("serial pulse width wrong");
    a_word_gap: assert property ($rose(ENC_SERIAL_OUT) |->
        out_lo == (FRAME_OSC - LONG_HIGH_OSC) * DIV ||
        out_lo == (FRAME_OSC - SHORT_HIGH_OSC) * DIV ||
        out_lo >= WORD_GAP_PERIODS * PERIOD_OSC * DIV)
        else $error("serial low time wrong");
    a_nibble_valid: assert property ($changed(DECODED_NIBBLE_OUT) |->
        $rose(VALID_RECEPTION))
        else $error("nibble changed without valid");
    a_valid_gap: assert property ($rose(VALID_RECEPTION) |->
        din_lo >= GAP_C - 1 && din_lo <= GAP_C + 4)
        else $error("valid rose away from word end");
    a_valid_eot: assert property (din_lo > EOT_C + 3 |->
        !VALID_RECEPTION)
        else $error("valid held past end of transmission");
endmodule
bind trinary_code_pair code_pair_properties #(.OSC_HZ_P(OSC_HZ_P)) i_props (
    .MCLK(MCLK), .RESETN(RESETN), .ENC_SERIAL_OUT(ENC_SERIAL_OUT),
    .ADDRESS_DIGITS_OUT(ADDRESS_DIGITS_OUT),
    .ADDRESS_DIGITS_OE_N(ADDRESS_DIGITS_OE_N),
    .SHARED_ADDR_DATA_DIGITS_OE_N(SHARED_ADDR_DATA_DIGITS_OE_N),
    .DEC_SERIAL_IN(DEC_SERIAL_IN), .DECODED_NIBBLE_OUT(DECODED_NIBBLE_OUT),
    .VALID_RECEPTION(VALID_RECEPTION));
`default_nettype wire

/* File: sim/code_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none
module code_pins_model
    import code_pair_pkg::*;
(
    // clock and pin settings
    input wire logic clk,
    input wire logic [2*DIGITS-1:0] cfg,
    // weak probe drive
    input wire logic [DIGITS-1:0] drv,
    input wire logic [DIGITS-1:0] drv_oe_n,
    // resolved pin levels
    output logic [DIGITS-1:0] level
);
    logic [DIGITS-1:0] last;
    always_ff @(posedge clk) begin
        for (int i = 0; i < DIGITS; i++) begin
            if (!drv_oe_n[i]) begin
                last[i] <= drv[i];
            end
        end
    end
    // tied pins ignore the probe, open pins follow it
    always_comb begin
        for (int i = 0; i < DIGITS; i++) begin
            case (cfg[2*i +: 2])
                TRIT_LOW: level[i] = 1'b0;
                TRIT_HIGH: level[i] = 1'b1;
                default: level[i] = drv_oe_n[i] ? ~last[i] : drv[i];
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: sim/trinary_code_pair_test.sv */
`timescale 1ns/10ps
`default_nettype none
module trinary_code_pair_test
    import code_pair_pkg::*;
;
    localparam int DIV = 10;
    typedef struct packed {
        logic [17:0] pins;
        logic [17:0] here;
        logic [3:0] nib;
        logic vld;
    } row_s;
    localparam row_s ROWS [5] = '{
        '{18'h0_0000, 18'h0_0000, 4'h0, 1'b1},
        '{18'h1_1249, 18'h1_1249, 4'ha, 1'b1},
        '{18'h2_a955, 18'h2_a955, 4'hf, 1'b1},
        '{18'h1_1249, 18'h1_1245, 4'hf, 1'b0},
        '{18'h0_0000, 18'h0_0002, 4'hf, 1'b0}};
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic send_n = 1'b1;
    logic use_bench = 1'b0;
    logic bench_din = 1'b0;
    logic seen = 1'b0;
    logic seen9 = 1'b0;
    logic [17:0] pin_cfg = 18'h0_0000;
    logic [17:0] local_address = 18'h0_0000;
    wire [8:0] pin_level, pin_drv, pin_oe_n;
    wire [3:0] nibble;
    wire enc_out, dec_in, valid, valid9;
    int fail_count = 0;
    int n_tests = 0;
    always #50 mclk = ~mclk;
    assign dec_in = use_bench ? bench_din : enc_out;
    trinary_code_pair #(.OSC_HZ_P(1_000_000)) i_dut (
        .MCLK(mclk), .RESETN(resetn), .SEND_REQUEST_N(send_n),
        .ENC_SERIAL_OUT(enc_out), .ADDRESS_DIGITS_IN(pin_level[4:0]),
        .ADDRESS_DIGITS_OUT(pin_drv[4:0]), .ADDRESS_DIGITS_OE_N(pin_oe_n[4:0]),
        .SHARED_ADDR_DATA_DIGITS_IN(pin_level[8:5]),
        .SHARED_ADDR_DATA_DIGITS_OUT(pin_drv[8:5]),
        .SHARED_ADDR_DATA_DIGITS_OE_N(pin_oe_n[8:5]),
        .DEC_SERIAL_IN(dec_in), .LOCAL_ADDRESS(local_address),
        .DECODED_NIBBLE_OUT(nibble), .VALID_RECEPTION(valid));
    code_pins_model i_pins (.clk(mclk), .cfg(pin_cfg), .drv(pin_drv),
        .drv_oe_n(pin_oe_n), .level(pin_level));
    // address-only variant listening to the same stream
    trinary_code_pair #(.OSC_HZ_P(1_000_000), .ADDR_ONLY(1'b1)) i_dut9 (
        .MCLK(mclk), .RESETN(resetn), .SEND_REQUEST_N(1'b1),
        .ENC_SERIAL_OUT(), .ADDRESS_DIGITS_IN(5'h0),
        .ADDRESS_DIGITS_OUT(), .ADDRESS_DIGITS_OE_N(),
        .SHARED_ADDR_DATA_DIGITS_IN(4'h0), .SHARED_ADDR_DATA_DIGITS_OUT(),
        .SHARED_ADDR_DATA_DIGITS_OE_N(), .DEC_SERIAL_IN(dec_in),
        .LOCAL_ADDRESS(local_address), .DECODED_NIBBLE_OUT(),
        .VALID_RECEPTION(valid9));
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input bit lng);
        bench_din = 1'b1;
        step(lng ? 3 * DIV : DIV);
        bench_din = 1'b0;
        step(lng ? DIV : 3 * DIV);
    endtask
    // two pulses a digit, code 3 gives a short then long pair
    task automatic send_word(input logic [17:0] w);
        for (int d = 0; d < 9; d++) begin
            pulse(w[2*d +: 2] inside {2'h1, 2'h2});
            pulse(w[2*d +: 2] inside {2'h1, 2'h3});
        end
    endtask
    // one short request, then watch for valid
    task automatic request;
        send_n = 1'b0;
        step(1);
        send_n = 1'b1;
        seen = 1'b0;
        seen9 = 1'b0;
        repeat (3000) begin
            step(1);
            if (valid === 1'b1) seen = 1'b1;
            if (valid9 === 1'b1) seen9 = 1'b1;
        end
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        close_out;
    end
    initial begin
        step(8);
        resetn = 1'b1;
        request; // first sequence after power-up not judged
        foreach (ROWS[r]) begin
            pin_cfg = ROWS[r].pins;
            local_address = ROWS[r].here;
            request;
            check(seen, ROWS[r].vld);
            check(nibble, ROWS[r].nib);
            check(valid, 1'b0);
            check(seen9, ROWS[r].vld);
        end
        // request held low: sequences repeat and valid stays up
        pin_cfg = ROWS[1].pins;
        local_address = ROWS[1].here;
        send_n = 1'b0;
        step(3500);
        check(valid, 1'b1);
        check(nibble, ROWS[1].nib);
        check(valid9, 1'b1);
        send_n = 1'b1;
        step(3000);
        check(valid, 1'b0);
        check(enc_out, 1'b0);
        use_bench = 1'b1;
        local_address = 18'h1_1249;
        send_word(18'h1_1249);
        step(200);
        send_word(18'h1_1249);
        step(120);
        check(valid, 1'b0);
        step(10);
        check(valid, 1'b1);
        check(nibble, 4'ha);
        check(valid9, 1'b1);
        step(190);
        check(valid, 1'b1);
        step(10);
        check(valid, 1'b0);
        send_word(18'h1_1249);
        step(200);
        send_word(18'h1_1649);
        step(200);
        check(valid, 1'b0);
        send_word(18'h1_1649);
        step(200);
        check(valid, 1'b1);
        check(nibble, 4'hb);
        check(valid9, 1'b0);
        send_word(18'h1_164b);
        step(200);
        check(valid, 1'b0);
        step(400);
        resetn = 1'b0;
        step(2);
        check(nibble, NIBBLE_RESET);
        check(valid, VALID_RESET);
        check(enc_out, 1'b0);
        resetn = 1'b1;
        step(2);
        close_out;
    end
endmodule
`default_nettype wire
